// >>> banked_data_memory_map.sv
`timescale 1ns/1ps
`include "dmm_defines.svh"

module banked_data_memory_map (
    input wire logic clk,
    input wire logic resetn,
    input wire dmm_pkg::core_req_t core_req,
    input wire logic [7:0] ext_rdata,
    output dmm_pkg::ext_req_t ext_req,
    output dmm_pkg::phase_t phase,
    output logic [7:0] rd_data,
    output logic [7:0] status,
    output logic [7:0] indirect_address_pointer,
    output logic [7:0] program_counter_low_byte,
    output logic [7:0] program_counter_latch,
    output logic [7:0] interrupt_control_register
);
    import dmm_pkg::*;

    state_t st;
    state_t next_st;
    // resolved access of the current instruction
    logic [8:0] full_addr;
    kind_t kind;
    logic [6:0] ram_idx;
    logic [7:0] read_value;
    logic write_now;

    // ==========================================================
    // address resolution
    function automatic logic [8:0] resolve(
        input logic [6:0] offset,
        input logic [7:0] flags,
        input logic [7:0] pointer
    );
        logic [8:0] a;
        // direct: both select bits sit above the offset
        a = {flags[`BANK_HI_BIT], flags[`BANK_LO_BIT], offset};
        // offset 00h follows the pointer, select high stays bit 8
        if (offset == `OFS_INDIRECT) begin
            a = {flags[`BANK_HI_BIT], pointer};
        end
        return a;
    endfunction

    // ram windows of banks 0 and 1
    function automatic logic in_ram(input logic [8:0] a);
        logic hit;
        hit = 1'h0;
        if (!a[7] && a[7:0] >= `GPR0_LO) begin
            hit = 1'h1;
        end
        if (a[7] && a[7:0] >= `GPR1_LO && a[7:0] <= `GPR1_HI) begin
            hit = 1'h1;
        end
        return hit;
    endfunction

    // peripheral registers kept outside this block
    function automatic logic in_ext(input logic [8:0] a);
        logic [31:0] map;
        logic hit;
        map = a[7] ? `EXT_MAP_BANK1 : `EXT_MAP_BANK0;
        hit = 1'h0;
        // only offsets below 20h can hold a peripheral
        if (a[6:0] < `SFR_SPAN) begin
            hit = map[a[4:0]];
        end
        return hit;
    endfunction

    function automatic kind_t decode(input logic [8:0] a);
        kind_t k;
        logic [6:0] off;
        off = a[6:0];
        k = K_NONE;
        // banks 2 and 3 hold nothing on the smallest variant
        if (!a[8]) begin
            case (off)
                `OFS_INDIRECT: k = K_IND;
                `OFS_PCL: k = K_PCL;
                `OFS_STATUS: k = K_STATUS;
                `OFS_FSR: k = K_FSR;
                `OFS_PROGRAM_COUNTER_LATCH: k = K_PROGRAM_COUNTER_LATCH;
                `OFS_INTERRUPT_CONTROL_REGISTER: k = K_INTERRUPT_CONTROL_REGISTER;
                default: begin
                    if (in_ram(a)) begin
                        k = K_RAM;
                    end else if (in_ext(a)) begin
                        k = K_EXT;
                    end else begin
                        k = K_NONE;
                    end
                end
            endcase
        end
        return k;
    endfunction

    // bank 1 window sits after the 96 bytes of bank 0
    function automatic logic [6:0] ram_index(input logic [8:0] a);
        logic [7:0] i;
        if (a[7]) begin
            i = a[7:0] - `GPR1_LO + `GPR0_SIZE;
        end else begin
            i = a[7:0] - `GPR0_LO;
        end
        return i[6:0];
    endfunction

    assign full_addr = resolve(core_req.addr, st.status, st.indirect_address_pointer);
    assign kind = decode(full_addr);
    assign ram_idx = ram_index(full_addr);

    // ==========================================================
    // write-back qualifier
    assign write_now = (st.phase == Q4) && core_req.wr_en;

    // ==========================================================
    // read multiplexer
    // mirrored offsets of both banks share one flop
    always_comb begin
        case (kind)
            K_PCL: read_value = st.program_counter_low_byte;
            K_STATUS: read_value = st.status;
            K_FSR: read_value = st.indirect_address_pointer;
            K_PROGRAM_COUNTER_LATCH: read_value = st.program_counter_latch;
            K_INTERRUPT_CONTROL_REGISTER: read_value = st.interrupt_control_register;
            K_RAM: read_value = st.ram[ram_idx];
            K_EXT: read_value = ext_rdata;
            default: read_value = `BYTE_ZERO;
        endcase
    end

    // ==========================================================
    // phase sequencing, operand read and write-back
    always_comb begin
        next_st = st;
        case (st.phase)
            Q1: begin
                // address and pointer settle
                next_st.phase = Q2;
            end
            Q2: begin
                // operand read
                next_st.phase = Q3;
                next_st.rdata = read_value;
            end
            Q3: begin
                next_st.phase = Q4;
            end
            Q4: begin
                // write-back, then the next cycle opens
                next_st.phase = Q1;
                if (write_now) begin
                    case (kind)
                        K_PCL: next_st.program_counter_low_byte = core_req.wdata;
                        K_STATUS: next_st.status = core_req.wdata;
                        K_FSR: next_st.indirect_address_pointer = core_req.wdata;
                        K_PROGRAM_COUNTER_LATCH: next_st.program_counter_latch = core_req.wdata;
                        K_INTERRUPT_CONTROL_REGISTER: next_st.interrupt_control_register = core_req.wdata;
                        K_RAM: next_st.ram[ram_idx] = core_req.wdata;
                        default: next_st.phase = Q1;
                    endcase
                end
            end
            default: begin
                next_st.phase = Q1;
            end
        endcase
    end

    // ==========================================================
    // peripheral strobes
    always_comb begin
        ext_req.addr = full_addr;
        ext_req.wdata = core_req.wdata;
        ext_req.rd = (st.phase == Q2) && (kind == K_EXT);
        ext_req.wr = write_now && (kind == K_EXT);
    end

    // ==========================================================
    // state register
    // synchronous reset; the cycle after release is q1
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st.phase <= Q1;
            st.rdata <= `BYTE_ZERO;
            st.status <= `STATUS_RST;
            st.indirect_address_pointer <= `FSR_RST;
            st.program_counter_low_byte <= `PCL_RST;
            st.program_counter_latch <= `PROGRAM_COUNTER_LATCH_RST;
            st.interrupt_control_register <= `INTERRUPT_CONTROL_REGISTER_RST;
            st.ram <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    // core registers are shown to the core directly
    assign phase = st.phase;
    assign rd_data = st.rdata;
    assign status = st.status;
    assign indirect_address_pointer = st.indirect_address_pointer;
    assign program_counter_low_byte = st.program_counter_low_byte;
    assign program_counter_latch = st.program_counter_latch;
    assign interrupt_control_register = st.interrupt_control_register;

endmodule

// >>> dmm_defines.svh
`ifndef DMM_DEFINES_SVH
`define DMM_DEFINES_SVH

// ==========================================================
// in-bank offsets of the core registers
`define OFS_INDIRECT 7'h00
`define OFS_PCL 7'h02
`define OFS_STATUS 7'h03
`define OFS_FSR 7'h04
`define OFS_PROGRAM_COUNTER_LATCH 7'h0A
`define OFS_INTERRUPT_CONTROL_REGISTER 7'h0B

// ==========================================================
// bank select field inside the core flags register
`define BANK_HI_BIT 6
`define BANK_LO_BIT 5

// ==========================================================
// general purpose ram windows (full 8-bit address, banks 0 and 1)
`define GPR0_LO 8'h20
`define GPR1_LO 8'hA0
`define GPR1_HI 8'hBF
`define GPR0_SIZE 8'h60
`define RAM_WORDS 128

// ==========================================================
// peripheral register maps, one bit per offset 00h..1Fh
`define EXT_MAP_BANK0 32'hC0FF_D0E2
`define EXT_MAP_BANK1 32'h801C_50E2
`define SFR_SPAN 7'h20

// ==========================================================
// reset values
`define STATUS_RST 8'h00
`define FSR_RST 8'h00
`define PCL_RST 8'h00
`define PROGRAM_COUNTER_LATCH_RST 8'h00
`define INTERRUPT_CONTROL_REGISTER_RST 8'h00
`define BYTE_ZERO 8'h00

`endif

// >>> dmm_pkg.sv
package dmm_pkg;

    // ==========================================================
    // quarter phases of one instruction cycle
    typedef enum logic [1:0] {
        Q1,
        Q2,
        Q3,
        Q4
    } phase_t;

    // ==========================================================
    // what a full data address decodes to
    typedef enum logic [3:0] {
        K_NONE,
        K_IND,
        K_PCL,
        K_STATUS,
        K_FSR,
        K_PROGRAM_COUNTER_LATCH,
        K_INTERRUPT_CONTROL_REGISTER,
        K_RAM,
        K_EXT
    } kind_t;

    // ==========================================================
    // operand access from the core
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr_en;
    } core_req_t;

    // ==========================================================
    // access to peripheral registers outside this block
    typedef struct packed {
        logic rd;
        logic wr;
        logic [8:0] addr;
        logic [7:0] wdata;
    } ext_req_t;

    // ==========================================================
    // complete state of the memory map
    typedef struct packed {
        phase_t phase;
        logic [7:0] rdata;
        logic [7:0] status;
        logic [7:0] indirect_address_pointer;
        logic [7:0] program_counter_low_byte;
        logic [7:0] program_counter_latch;
        logic [7:0] interrupt_control_register;
        logic [127:0][7:0] ram;
    } state_t;

endpackage

// >>> dmm_sva.sv
`timescale 1ns/1ps
module dmm_sva (
    input wire logic clk,
    input wire logic resetn,
    input wire dmm_pkg::core_req_t core_req,
    input wire logic [7:0] ext_rdata,
    input wire dmm_pkg::ext_req_t ext_req,
    input wire dmm_pkg::phase_t phase,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] status,
    input wire logic [7:0] indirect_address_pointer
);
    import dmm_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ==========================================================
    // checks
    sequence s_cycle;
        phase == Q1 ##1 phase == Q2 ##1 phase == Q3 ##1 phase == Q4;
    endsequence
    a_phase_order: assert property (phase == Q4 |=> s_cycle)
        else $error("bad phase order");
    a_read_q2: assert property (ext_req.rd |-> phase == Q2)
        else $error("read outside q2");
    a_write_q4: assert property (ext_req.wr |-> phase == Q4 && core_req.wr_en)
        else $error("write outside q4");
    a_ext_data: assert property (phase == Q2 && ext_req.rd
        |=> rd_data == $past(ext_rdata))
        else $error("bad peripheral data");
    a_direct_addr: assert property (ext_req.rd && core_req.addr != 7'h00
        |-> ext_req.addr == {status[6:5], core_req.addr})
        else $error("bad direct address");
    a_ind_addr: assert property (ext_req.rd && core_req.addr == 7'h00
        |-> ext_req.addr == {status[6], indirect_address_pointer})
        else $error("bad indirect address");
    a_bank_unimpl: assert property (phase == Q2 && status[6]
        |=> rd_data == 8'h00)
        else $error("bank two or three not zero");
    a_fsr_write: assert property (phase == Q4 && core_req.wr_en
        && core_req.addr == 7'h04 && !status[6]
        |=> indirect_address_pointer == $past(core_req.wdata))
        else $error("pointer not written");
endmodule
bind banked_data_memory_map dmm_sva i_dmm_sva (.clk(clk), .resetn(resetn),
    .core_req(core_req), .ext_rdata(ext_rdata), .ext_req(ext_req),
    .phase(phase), .rd_data(rd_data), .status(status), .indirect_address_pointer(indirect_address_pointer));

// >>> periph_model.sv
`timescale 1ns/1ps
module periph_model (
    input wire logic clk,
    input wire dmm_pkg::ext_req_t ext_req,
    output logic [7:0] ext_rdata
);
    import dmm_pkg::*;
    logic [7:0] mem [512];
    logic [7:0] last = 8'h00;
    initial for (int i = 0; i < 512; i++) mem[i] = 8'h3C;
    // idle bus shows the inverse of the last byte
    assign ext_rdata = ext_req.rd ? mem[ext_req.addr] : ~last;
    always @(posedge clk) begin
        last <= ext_rdata;
        if (ext_req.wr) mem[ext_req.addr] <= ext_req.wdata;
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dmm_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    core_req_t core_req = '0;
    ext_req_t ext_req;
    phase_t phase;
    logic [7:0] ext_rdata, rd_data, status, indirect_address_pointer, program_counter_low_byte, program_counter_latch, interrupt_control_register, r, v;
    int bad_count = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    banked_data_memory_map i_banked_data_memory_map (.clk(clk),
        .resetn(resetn), .core_req(core_req), .ext_rdata(ext_rdata),
        .ext_req(ext_req), .phase(phase), .rd_data(rd_data),
        .status(status), .indirect_address_pointer(indirect_address_pointer), .program_counter_low_byte(program_counter_low_byte), .program_counter_latch(program_counter_latch),
        .interrupt_control_register(interrupt_control_register));
    periph_model i_periph_model (.clk(clk), .ext_req(ext_req),
        .ext_rdata(ext_rdata));
    // ==========================================================
    // helpers
    task step;
        @(posedge clk);
        #5;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task op(input logic [6:0] a, input logic [7:0] d, input logic w);
        while (phase !== Q1) step;
        core_req = '{addr: a, wdata: d, wr_en: w};
        repeat (2) step;
        r = rd_data;
        repeat (2) step;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        op(a, 8'h00, 1'b0);
        chk(r, e);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task t_ram;
        op(7'h03, 8'h00, 1);
        op(7'h20, 8'hA5, 1);
        op(7'h7F, 8'h5A, 1);
        op(7'h03, 8'h20, 1);
        op(7'h20, 8'hC3, 1);
        op(7'h40, 8'h77, 1);
        rd(7'h20, 8'hC3);
        rd(7'h40, 8'h00);
        op(7'h03, 8'h00, 1);
        rd(7'h7F, 8'h5A);
        op(7'h20, 8'h11, 1);
        chk(r, 8'hA5);
        rd(7'h20, 8'h11);
        $display("t_ram done");
    endtask
    task t_mirror;
        logic [6:0] ofs [4];
        ofs = '{7'h02, 7'h04, 7'h0A, 7'h0B};
        v = 8'h40;
        for (int i = 0; i < 4; i++) begin
            op(7'h03, 8'h20, 1);
            op(ofs[i], v + 8'(i), 1);
            op(7'h03, 8'h00, 1);
            rd(ofs[i], v + 8'(i));
        end
        chk(program_counter_low_byte, 8'h40);
        chk(program_counter_latch, 8'h42);
        chk(interrupt_control_register, 8'h43);
        $display("t_mirror done");
    endtask
    task t_indirect;
        op(7'h04, 8'h25, 1);
        op(7'h00, 8'hE1, 1);
        rd(7'h25, 8'hE1);
        op(7'h04, 8'hA1, 1);
        op(7'h00, 8'hB2, 1);
        op(7'h03, 8'h20, 1);
        rd(7'h21, 8'hB2);
        op(7'h04, 8'h00, 1);
        rd(7'h00, 8'h00);
        $display("t_indirect done");
    endtask
    task t_periph;
        op(7'h05, 8'h6D, 1);
        rd(7'h05, 8'h6D);
        rd(7'h18, 8'h00);
        op(7'h03, 8'h00, 1);
        rd(7'h05, 8'h3C);
        $display("t_periph done");
    endtask
    task t_bank2;
        op(7'h03, 8'h40, 1);
        op(7'h20, 8'h55, 1);
        rd(7'h20, 8'h00);
        resetn = 1'b0;
        repeat (2) step;
        resetn = 1'b1;
        rd(7'h03, 8'h00);
        $display("t_bank2 done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #5;
        resetn = 1'b1;
        t_ram;
        t_mirror;
        t_indirect;
        t_periph;
        t_bank2;
        summarize;
    end
    initial begin
        #100000;
        bad_count++;
        summarize;
    end
endmodule
